// file: hdl/timer_pkg.sv
// constants, types and field layout of the dual compare timer
package timer_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam logic [15:0] PORT1_DIRECTION_ADDR = 16'hff21;
	localparam logic [15:0] PORT1_LATCH_ADDR = 16'hff01;
	localparam logic [15:0] TIMER_MODE_ADDR = 16'hff6c;
	localparam logic [15:0] CARRIER_CTRL_ADDR = 16'hff6d;
	localparam logic [15:0] CYCLE_COMPARE_ADDR = 16'hff0e;
	localparam logic [15:0] DUTY_COMPARE_ADDR = 16'hff0f;

	localparam logic [7:0] PORT1_DIRECTION_RESET = 8'hff;
	localparam logic [7:0] PORT1_LATCH_RESET = 8'h00;
	localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
	localparam logic [7:0] CARRIER_CTRL_RESET = 8'h00;
	localparam logic [7:0] COMPARE_RESET = 8'h00;

	localparam int OUTPUT_PIN_BIT = 6;
	localparam int TIMER_ENABLE_POS = 7;
	localparam int CLOCK_SELECT_LSB = 4;
	localparam int MODE_SELECT_LSB = 2;
	localparam int DEFAULT_LEVEL_POS = 1;
	localparam int OUTPUT_ENABLE_POS = 0;
	localparam int REMOTE_ENABLE_POS = 2;
	localparam int REMOTE_LEVEL_POS = 1;
	localparam int CARRIER_STATUS_POS = 0;

	// count clock dividers as masks of prescaler or low-speed edge counter low bits
	localparam logic [11:0] DIV4_MASK = 12'h003;
	localparam logic [11:0] DIV16_MASK = 12'h00f;
	localparam logic [11:0] DIV64_MASK = 12'h03f;
	localparam logic [11:0] DIV4096_MASK = 12'hfff;
	localparam logic [8:0] LS_DIV128_MASK = 9'h07f;
	localparam logic [8:0] LS_DIV512_MASK = 9'h1ff;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0]
	{
		CLK_PRS = 3'h0,
		CLK_PRS_DIV4 = 3'h1,
		CLK_PRS_DIV16 = 3'h2,
		CLK_PRS_DIV64 = 3'h3,
		CLK_PRS_DIV4096 = 3'h4,
		CLK_LS_DIV128 = 3'h5,
		CLK_LS_DIV512 = 3'h6,
		CLK_LS = 3'h7
	} clock_select_t;

	typedef enum logic [1:0]
	{
		MODE_INTERVAL = 2'h0,
		MODE_CARRIER = 2'h1,
		MODE_PWM = 2'h2,
		MODE_PROHIBITED = 2'h3
	} op_mode_t;

	// gray along idle -> cycle -> duty
	typedef enum logic [1:0]
	{
		PH_IDLE = 2'h0,
		PH_CYCLE = 2'h1,
		PH_DUTY = 2'h3
	} phase_t;

	typedef struct packed
	{
		logic timer_enable_bit;
		clock_select_t clock_select;
		op_mode_t mode_select;
		logic default_output_level;
		logic output_enable_bit;
	} timer_mode_t;

	typedef struct packed
	{
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

// file: hdl/count_clock_gen.sv
// count clock tick generator from prescaled or low-speed clocks
`timescale 1ns/100ps
`default_nettype none
module count_clock_gen
	import timer_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic clk_en_in,
	input wire timer_pkg::clock_select_t clock_select_in,
	input wire logic low_speed_osc_in,
	output logic tick_out
);

	typedef struct packed
	{
		logic [11:0] prescale;
		logic [8:0] ls_count;
		logic ls_prev;
	} gen_state_t;

	gen_state_t q, d;
	logic ls_edge;

	function automatic logic ones12(input logic [11:0] v, input logic [11:0] m);
		ones12 = (v & m) == m;
	endfunction

	function automatic logic ones9(input logic [8:0] v, input logic [8:0] m);
		ones9 = (v & m) == m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	assign ls_edge = low_speed_osc_in & ~q.ls_prev;

	always_comb
	begin
		d = q;
		d.prescale = q.prescale + 12'h001;
		d.ls_prev = low_speed_osc_in;
		if (ls_edge)
		begin
			d.ls_count = q.ls_count + 9'h001;
		end
	end

	// one tick per selected count clock edge
	always_comb
	begin
		case (clock_select_in)
			CLK_PRS: tick_out = 1'b1;
			CLK_PRS_DIV4: tick_out = ones12(q.prescale, DIV4_MASK);
			CLK_PRS_DIV16: tick_out = ones12(q.prescale, DIV16_MASK);
			CLK_PRS_DIV64: tick_out = ones12(q.prescale, DIV64_MASK);
			CLK_PRS_DIV4096: tick_out = ones12(q.prescale, DIV4096_MASK);
			CLK_LS_DIV128: tick_out = ls_edge & ones9(q.ls_count, LS_DIV128_MASK);
			CLK_LS_DIV512: tick_out = ls_edge & ones9(q.ls_count, LS_DIV512_MASK);
			CLK_LS: tick_out = ls_edge;
			default: tick_out = 1'b0;
		endcase
		tick_out = tick_out & clk_en_in;
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			q <= '0;
		end
		else if (clk_en_in)
		begin
			q <= d;
		end
	end

endmodule
`default_nettype wire

// file: hdl/duty_latch.sv
// duty compare register with its pending-write latch
`timescale 1ns/100ps
`default_nettype none
module duty_latch
	import timer_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic clk_en_in,
	input wire logic write_in,
	input wire logic [7:0] wdata_in,
	input wire logic running_in,
	input wire logic match_in,
	output logic [7:0] active_out,
	output logic [7:0] readback_out
);

	typedef struct packed
	{
		logic [7:0] active;
		logic [7:0] pending;
		logic pend;
	} duty_state_t;

	duty_state_t q, d;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		if (!running_in)
		begin
			if (write_in)
			begin
				d.active = wdata_in;
				d.pending = wdata_in;
				d.pend = 1'b0;
			end
		end
		else if (write_in)
		begin
			// a write racing a match only parks the value
			d.pending = wdata_in;
			d.pend = 1'b1;
		end
		else if (match_in && q.pend)
		begin
			d.active = q.pending;
			d.pend = 1'b0;
		end
	end

	assign active_out = q.active;
	assign readback_out = q.pending;

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			q <= '{active: COMPARE_RESET, pending: COMPARE_RESET, pend: 1'b0};
		end
		else if (clk_en_in)
		begin
			q <= d;
		end
	end

endmodule
`default_nettype wire

// file: hdl/dual_compare_timer.sv
// eight bit dual compare timer with carrier and port pin control
`timescale 1ns/100ps
`default_nettype none
module dual_compare_timer
	import timer_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic clk_en_in,
	input wire timer_pkg::reg_req_t reg_req_in,
	output logic [7:0] reg_rdata_out,
	input wire logic low_speed_osc_in,
	input wire logic companion_counter_interrupt_in,
	output logic match_interrupt_out,
	output logic timer_output_pin_out,
	output logic timer_output_pin_oe_out
);

	typedef struct packed
	{
		timer_mode_t mode;
		logic remote_control_enable;
		logic remote_level_buffer;
		logic carrier_status_flag;
		logic [7:0] cycle_compare;
		logic [7:0] port1_direction;
		logic [7:0] port1_latch;
		logic [7:0] counter;
		phase_t phase;
		logic wave;
		logic irq;
		logic pin;
		logic pin_oe;
		logic [7:0] rdata;
	} timer_state_t;

	timer_state_t q, d;
	logic tick;
	logic [7:0] duty_active;
	logic [7:0] duty_readback;
	logic duty_write;
	logic duty_match;
	logic running;
	logic carrier_wave;
	logic shaped;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
		hit = a == b;
	endfunction

	// the prohibited mode code falls back to interval behaviour
	function automatic logic is_carrier(input op_mode_t m);
		is_carrier = m == MODE_CARRIER;
	endfunction

	function automatic logic uses_duty(input op_mode_t m);
		uses_duty = m == MODE_PWM || m == MODE_CARRIER;
	endfunction

	// wraps at 8 bits; a compare below the count waits a full lap
	function automatic logic [7:0] bump(input logic [7:0] c);
		bump = c + 8'h01;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// prescaler runs free, so the first divided tick may come early
	count_clock_gen u_clock
	(
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.clk_en_in(clk_en_in),
		.clock_select_in(q.mode.clock_select),
		.low_speed_osc_in(low_speed_osc_in),
		.tick_out(tick)
	);

	// duty writes while running park in the latch until a match
	duty_latch u_duty
	(
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.clk_en_in(clk_en_in),
		.write_in(duty_write),
		.wdata_in(reg_req_in.wdata),
		.running_in(running),
		.match_in(duty_match),
		.active_out(duty_active),
		.readback_out(duty_readback)
	);

	////////////////////////////////////////////////////////////////////////
	assign running = q.mode.timer_enable_bit;
	assign duty_write = reg_req_in.wr & hit(reg_req_in.addr, DUTY_COMPARE_ADDR);
	// interval and prohibited modes never reach the duty phase
	assign duty_match = tick & running & (q.phase == PH_DUTY) &
		(q.counter == duty_active);

	// remote output: low unless status set; pulses when remote enabled
	always_comb
	begin
		if (!q.carrier_status_flag)
		begin
			carrier_wave = 1'b0;
		end
		else if (q.remote_control_enable)
		begin
			carrier_wave = q.wave;
		end
		else
		begin
			carrier_wave = 1'b1;
		end
	end

	always_comb
	begin
		if (!q.mode.output_enable_bit)
		begin
			shaped = 1'b0;
		end
		else if (is_carrier(q.mode.mode_select))
		begin
			shaped = carrier_wave;
		end
		else
		begin
			shaped = q.wave;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		// match interrupt drops after one cycle unless the next tick matches again
		d.irq = 1'b0;

		// register writes
		if (reg_req_in.wr)
		begin
			if (hit(reg_req_in.addr, TIMER_MODE_ADDR))
			begin
				d.mode = timer_mode_t'(reg_req_in.wdata);
			end
			if (hit(reg_req_in.addr, CARRIER_CTRL_ADDR))
			begin
				d.remote_control_enable = reg_req_in.wdata[REMOTE_ENABLE_POS];
				d.remote_level_buffer = reg_req_in.wdata[REMOTE_LEVEL_POS];
			end
			// taken even while running; software keeps it to stopped time
			if (hit(reg_req_in.addr, CYCLE_COMPARE_ADDR))
			begin
				d.cycle_compare = reg_req_in.wdata;
			end
			if (hit(reg_req_in.addr, PORT1_DIRECTION_ADDR))
			begin
				d.port1_direction = reg_req_in.wdata;
			end
			if (hit(reg_req_in.addr, PORT1_LATCH_ADDR))
			begin
				d.port1_latch = reg_req_in.wdata;
			end
		end

		// companion counter event loads the carrier status
		if (companion_counter_interrupt_in)
		begin
			d.carrier_status_flag = q.remote_level_buffer;
		end

		// a level written along with the enable bit holds until first match
		if (running && q.phase == PH_IDLE)
		begin
			d.wave = q.mode.default_output_level;
		end

		// counting
		if (!running)
		begin
			d.counter = 8'h00;
			d.phase = PH_IDLE;
			d.wave = q.mode.default_output_level;
		end
		else if (tick)
		begin
			case (q.phase)
				PH_IDLE:
				begin
					// first count clock is swallowed
					d.phase = PH_CYCLE;
				end
				PH_CYCLE:
				begin
					if (q.counter == q.cycle_compare)
					begin
						d.counter = 8'h00;
						d.wave = ~q.wave;
						d.irq = 1'b1;
						if (uses_duty(q.mode.mode_select))
						begin
							d.phase = PH_DUTY;
						end
					end
					else
					begin
						d.counter = bump(q.counter);
					end
				end
				PH_DUTY:
				begin
					d.phase = PH_CYCLE;
					if (duty_match)
					begin
						d.wave = ~q.wave;
						if (is_carrier(q.mode.mode_select))
						begin
							d.counter = 8'h00;
							d.irq = 1'b1;
						end
						else
						begin
							// pwm keeps counting through the duty match
							d.counter = bump(q.counter);
						end
					end
					else
					begin
						d.phase = PH_DUTY;
						d.counter = bump(q.counter);
					end
				end
				default:
				begin
					d.phase = PH_IDLE;
				end
			endcase
		end

		// port pin: driven when direction bit clear
		d.pin_oe = ~q.port1_direction[OUTPUT_PIN_BIT];
		// a set latch bit forces the pin high over the waveform
		d.pin = q.port1_latch[OUTPUT_PIN_BIT] | shaped;

		// registered read data, unmapped reads as zero
		if (reg_req_in.rd)
		begin
			d.rdata = 8'h00;
			if (hit(reg_req_in.addr, TIMER_MODE_ADDR))
			begin
				d.rdata = q.mode;
			end
			if (hit(reg_req_in.addr, CARRIER_CTRL_ADDR))
			begin
				d.rdata = {5'h00, q.remote_control_enable,
					q.remote_level_buffer, q.carrier_status_flag};
			end
			if (hit(reg_req_in.addr, CYCLE_COMPARE_ADDR))
			begin
				d.rdata = q.cycle_compare;
			end
			// duty reads show the parked value, not the one in use
			if (hit(reg_req_in.addr, DUTY_COMPARE_ADDR))
			begin
				d.rdata = duty_readback;
			end
			if (hit(reg_req_in.addr, PORT1_DIRECTION_ADDR))
			begin
				d.rdata = q.port1_direction;
			end
			if (hit(reg_req_in.addr, PORT1_LATCH_ADDR))
			begin
				d.rdata = q.port1_latch;
			end
		end
	end

	assign reg_rdata_out = q.rdata;
	assign match_interrupt_out = q.irq;
	assign timer_output_pin_out = q.pin;
	assign timer_output_pin_oe_out = q.pin_oe;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			// non-zero reset fields are set after the blanket clear
			q <= '0;
			q.mode <= timer_mode_t'(TIMER_MODE_RESET);
			q.remote_control_enable <= CARRIER_CTRL_RESET[REMOTE_ENABLE_POS];
			q.remote_level_buffer <= CARRIER_CTRL_RESET[REMOTE_LEVEL_POS];
			q.carrier_status_flag <= CARRIER_CTRL_RESET[CARRIER_STATUS_POS];
			q.cycle_compare <= COMPARE_RESET;
			q.port1_direction <= PORT1_DIRECTION_RESET;
			q.port1_latch <= PORT1_LATCH_RESET;
			q.phase <= PH_IDLE;
		end
		else if (clk_en_in)
		begin
			q <= d;
		end
	end

endmodule
`default_nettype wire

// file: tb/dual_compare_timer_props.sv
// port-level properties of the dual compare timer
`timescale 1ns/100ps
`default_nettype none
module dual_compare_timer_props
	import timer_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic clk_en_in,
	input wire timer_pkg::reg_req_t reg_req_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic low_speed_osc_in,
	input wire logic companion_counter_interrupt_in,
	input wire logic match_interrupt_out,
	input wire logic timer_output_pin_out,
	input wire logic timer_output_pin_oe_out
);
	logic [7:0] mode_q, cyc_q;
	logic [1:0] car_q;
	logic dir_q, lat_q, wr_ok, rd_ok;
	assign wr_ok = reg_req_in.wr && clk_en_in;
	assign rd_ok = reg_req_in.rd && clk_en_in;
	////////////////////////////////////////////////////////////////////////
	// shadow of the written registers, so outputs can be tied to settings
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			mode_q <= 8'h00;
			cyc_q <= 8'h00;
			car_q <= 2'h0;
			dir_q <= 1'b1;
			lat_q <= 1'b0;
		end
		else if (wr_ok)
		begin
			case (reg_req_in.addr)
				TIMER_MODE_ADDR: mode_q <= reg_req_in.wdata;
				CYCLE_COMPARE_ADDR: cyc_q <= reg_req_in.wdata;
				CARRIER_CTRL_ADDR: car_q <= reg_req_in.wdata[2:1];
				PORT1_DIRECTION_ADDR: dir_q <= reg_req_in.wdata[6];
				PORT1_LATCH_ADDR: lat_q <= reg_req_in.wdata[6];
				default: ;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	property p_stop_quiet;
		!mode_q[7] [*3] |-> !match_interrupt_out;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("irq while stopped");
	property p_oe;
		dir_q == $past(dir_q) |-> timer_output_pin_oe_out == !dir_q;
	endproperty
	a_oe: assert property (p_oe)
		else $error("pin enable differs from direction");
	property p_idle_pin;
		(!mode_q[7] && !lat_q && $stable(mode_q) && mode_q[3:2] != 2'h1) [*3]
			|-> timer_output_pin_out == (mode_q[1] & mode_q[0]);
	endproperty
	a_idle_pin: assert property (p_idle_pin)
		else $error("idle pin level wrong");
	property p_mode_read;
		rd_ok && reg_req_in.addr == TIMER_MODE_ADDR
			|=> reg_rdata_out == $past(mode_q);
	endproperty
	a_mode_read: assert property (p_mode_read)
		else $error("mode readback wrong");
	property p_car_read;
		rd_ok && reg_req_in.addr == CARRIER_CTRL_ADDR
			|=> reg_rdata_out[7:1] == {5'h00, $past(car_q)};
	endproperty
	a_car_read: assert property (p_car_read)
		else $error("carrier readback wrong");
	property p_irq_pulse;
		match_interrupt_out && mode_q[6:4] != 3'h0 |=> !match_interrupt_out;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("irq longer than one cycle");
	property p_irq_source;
		match_interrupt_out |-> $past(mode_q[7]) || $past(mode_q[7], 2);
	endproperty
	a_irq_source: assert property (p_irq_source)
		else $error("irq without enable");
	// one masked tick, then two counts to reach a cycle compare of one
	property p_first_irq;
		$rose(mode_q[7]) && mode_q[6:2] == 5'h00 && cyc_q == 8'h01
			|-> !match_interrupt_out [*3] ##[1:2] match_interrupt_out;
	endproperty
	a_first_irq: assert property (p_first_irq)
		else $error("first irq at wrong time");
endmodule
bind dual_compare_timer dual_compare_timer_props u_props (
	.ref_clk_in(ref_clk_in),
	.rstn_in(rstn_in),
	.clk_en_in(clk_en_in),
	.reg_req_in(reg_req_in),
	.reg_rdata_out(reg_rdata_out),
	.low_speed_osc_in(low_speed_osc_in),
	.companion_counter_interrupt_in(companion_counter_interrupt_in),
	.match_interrupt_out(match_interrupt_out),
	.timer_output_pin_out(timer_output_pin_out),
	.timer_output_pin_oe_out(timer_output_pin_oe_out)
);
`default_nettype wire

// file: tb/companion_model.sv
// companion event counter pulses and low-speed oscillator
`timescale 1ns/100ps
`default_nettype none
module companion_model
#(
	parameter int PULSE_GAP = 40,
	parameter int OSC_HALF = 2
)
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	output logic companion_counter_interrupt_out,
	output logic low_speed_osc_out
);
	int gap_q, osc_q;
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			gap_q <= 0;
			osc_q <= 0;
			companion_counter_interrupt_out <= 1'b0;
			low_speed_osc_out <= 1'b0;
		end
		else
		begin
			// slow pulses keep the timer clock over six times faster
			gap_q <= (gap_q == PULSE_GAP - 1) ? 0 : gap_q + 1;
			companion_counter_interrupt_out <= gap_q == PULSE_GAP - 1;
			osc_q <= (osc_q == OSC_HALF - 1) ? 0 : osc_q + 1;
			if (osc_q == OSC_HALF - 1)
				low_speed_osc_out <= !low_speed_osc_out;
		end
	end
endmodule
`default_nettype wire

// file: tb/dual_compare_timer_tb.sv
// self-checking bench for the dual compare timer
`timescale 1ns/100ps
`default_nettype none
module dual_compare_timer_tb;
	import timer_pkg::*;
	logic clk, rstn_n, osc, comp, irq, pin, oe;
	logic [7:0] rdata;
	reg_req_t req;
	int failures, n_checks;
	dual_compare_timer dut (
		.ref_clk_in(clk),
		.rstn_in(rstn_n),
		.clk_en_in(1'b1),
		.reg_req_in(req),
		.reg_rdata_out(rdata),
		.low_speed_osc_in(osc),
		.companion_counter_interrupt_in(comp),
		.match_interrupt_out(irq),
		.timer_output_pin_out(pin),
		.timer_output_pin_oe_out(oe)
	);
	companion_model partner (
		.ref_clk_in(clk),
		.rstn_in(rstn_n),
		.companion_counter_interrupt_out(comp),
		.low_speed_osc_out(osc)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_n(string what, int exp, int got);
		n_checks++;
		if (got != exp)
		begin
			failures++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic idle(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// strobes drop with an idle cycle after, never re-raised in one step
	task automatic wr(logic [15:0] a, logic [7:0] d);
		req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		idle(1);
		req.wr = 1'b0;
		idle(1);
	endtask
	task automatic rchk(string what, logic [15:0] a, logic [7:0] exp);
		req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		idle(1);
		req.rd = 1'b0;
		check8(what, exp, rdata);
		idle(1);
	endtask
	task automatic next_irq(output int n);
		n = 0;
		do
		begin
			idle(1);
			n++;
		end
		while (irq !== 1'b1 && n < 20000);
	endtask
	task automatic spacing(output int s);
		next_irq(s);
		next_irq(s);
	endtask
	task automatic measure(int len, output int hi, output int ni);
		next_irq(hi);
		hi = 0;
		ni = 0;
		repeat (len)
		begin
			// an unknown level is counted far off so it cannot pass
			hi += (pin === 1'b1) ? 1 : (pin === 1'b0) ? 0 : 1000;
			ni += (irq === 1'b1) ? 1 : (irq === 1'b0) ? 0 : 1000;
			idle(1);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rchk("mode", TIMER_MODE_ADDR, TIMER_MODE_RESET);
		rchk("carrier", CARRIER_CTRL_ADDR, CARRIER_CTRL_RESET);
		rchk("dir", PORT1_DIRECTION_ADDR, PORT1_DIRECTION_RESET);
		rchk("cycle", CYCLE_COMPARE_ADDR, COMPARE_RESET);
		rchk("duty", DUTY_COMPARE_ADDR, COMPARE_RESET);
		rchk("unmapped", 16'hff6e, 8'h00);
		wr(CARRIER_CTRL_ADDR, 8'hf9);
		rchk("carrier ro", CARRIER_CTRL_ADDR, 8'h00);
		check8("oe off", 8'h00, {7'h00, oe});
		$display("test reset done");
	endtask
	task automatic t_interval;
		int s;
		logic p;
		wr(PORT1_DIRECTION_ADDR, 8'hbf);
		check8("oe on", 8'h01, {7'h00, oe});
		wr(CYCLE_COMPARE_ADDR, 8'h01);
		wr(TIMER_MODE_ADDR, 8'h81);
		spacing(s);
		check_n("interval", 2, s);
		p = pin;
		next_irq(s);
		check8("toggle", {7'h00, !p}, {7'h00, pin});
		wr(TIMER_MODE_ADDR, 8'h01);
		idle(1);
		check8("stop pin", 8'h00, {7'h00, pin});
		wr(TIMER_MODE_ADDR, 8'h03);
		idle(1);
		check8("idle high", 8'h01, {7'h00, pin});
		wr(TIMER_MODE_ADDR, 8'h02);
		idle(1);
		check8("out off", 8'h00, {7'h00, pin});
		$display("test interval done");
	endtask
	task automatic t_pwm;
		int hi, ni;
		wr(CYCLE_COMPARE_ADDR, 8'h04);
		wr(DUTY_COMPARE_ADDR, 8'h01);
		wr(TIMER_MODE_ADDR, 8'h89);
		measure(10, hi, ni);
		check_n("pwm high", 4, hi);
		check_n("pwm irqs", 2, ni);
		wr(DUTY_COMPARE_ADDR, 8'h02);
		rchk("duty read", DUTY_COMPARE_ADDR, 8'h02);
		next_irq(hi);
		measure(10, hi, ni);
		check_n("pwm new", 6, hi);
		wr(TIMER_MODE_ADDR, 8'h09);
		$display("test pwm done");
	endtask
	task automatic t_carrier;
		int hi, ni;
		wr(CARRIER_CTRL_ADDR, 8'h06);
		wr(CYCLE_COMPARE_ADDR, 8'h03);
		wr(DUTY_COMPARE_ADDR, 8'h01);
		wr(TIMER_MODE_ADDR, 8'h85);
		idle(45);
		rchk("flag set", CARRIER_CTRL_ADDR, 8'h07);
		measure(12, hi, ni);
		check_n("carrier irqs", 4, ni);
		check_n("carrier high", 4, hi);
		wr(CARRIER_CTRL_ADDR, 8'h04);
		idle(45);
		rchk("flag clr", CARRIER_CTRL_ADDR, 8'h04);
		measure(12, hi, ni);
		check_n("carrier low", 0, hi);
		wr(TIMER_MODE_ADDR, 8'h05);
		$display("test carrier done");
	endtask
	task automatic t_clocks;
		int div[8] = '{1, 4, 16, 64, 4096, 512, 2048, 4};
		int s;
		wr(CYCLE_COMPARE_ADDR, 8'h00);
		for (int c = 0; c < 8; c++)
		begin
			// clock bits change only while stopped
			wr(TIMER_MODE_ADDR, {1'b0, 3'(c), 4'h0});
			wr(TIMER_MODE_ADDR, {1'b1, 3'(c), 4'h0});
			spacing(s);
			check_n("divider", div[c], s);
			wr(TIMER_MODE_ADDR, {1'b0, 3'(c), 4'h0});
		end
		wr(TIMER_MODE_ADDR, 8'h00);
		$display("test clocks done");
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #10 clk = !clk;
	end
	// whole run is about 20k cycles, so this only trips on a hang
	initial
	begin
		#2000000;
		failures++;
		conclude();
	end
	initial
	begin
		rstn_n = 1'b0;
		req = '0;
		failures = 0;
		n_checks = 0;
		idle(16);
		rstn_n = 1'b1;
		t_reset();
		t_interval();
		t_pwm();
		t_carrier();
		t_clocks();
		conclude();
	end
endmodule
`default_nettype wire
